// ===== hdl/feapc_defs.vh
// register map, field positions and reset values of the error front end
// assumes a 32-bit register bus with byte addresses
`ifndef FEAPC_DEFS_VH
`define FEAPC_DEFS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define FEAPC_ADDR_STATUS 32'h000e0004
`define FEAPC_ADDR_STEP 32'h000e0014
`define FEAPC_ADDR_SATSTEP 32'h000e0018
`define FEAPC_ADDR_CTRL 32'h000e0020
`define FEAPC_ADDR_PREBIAS 32'h000e0028
// ----------------------------------------
// reset values
// ----------------------------------------
`define FEAPC_RST_STEP 18'h00000
`define FEAPC_RST_SATSTEP 14'h0000
`define FEAPC_RST_CTRL 29'h0000003f
`define FEAPC_RST_PREBIAS 18'h0ff00
// ----------------------------------------
// control register fields
// ----------------------------------------
`define FEAPC_CTRL_CMPEN 28
`define FEAPC_CTRL_TRIPHI 27
`define FEAPC_CTRL_TRIPLO 26
`define FEAPC_CTRL_DECIM 25:22
`define FEAPC_CTRL_FSYNC 21
`define FEAPC_CTRL_CCLR 20
`define FEAPC_CTRL_CPRE 19:16
`define FEAPC_CTRL_INV 15
`define FEAPC_CTRL_AGMODE 14
`define FEAPC_CTRL_AGEN 13
`define FEAPC_CTRL_WEIGHT 12
`define FEAPC_CTRL_SPATIAL 11
`define FEAPC_CTRL_DEPTH 10:9
`define FEAPC_CTRL_MODE 8:6
`define FEAPC_CTRL_GAIN 5:4
`define FEAPC_CTRL_NFILT 3
`define FEAPC_CTRL_CLKFULL 2
`define FEAPC_CTRL_SCEN 1
`define FEAPC_CTRL_CONVEN 0
// ----------------------------------------
// pre-bias register fields
// ----------------------------------------
`define FEAPC_PB_POL 17
`define FEAPC_PB_EN 16
`define FEAPC_PB_RANGE 15:8
`define FEAPC_PB_LIMIT 7:0
// ----------------------------------------
// operating modes and gains
// ----------------------------------------
`define FEAPC_MODE_STD 3'h0
`define FEAPC_MODE_AVG 3'h1
`define FEAPC_MODE_NSAR 3'h2
`define FEAPC_MODE_CSAR 3'h3
`define FEAPC_MODE_PEAK 3'h5
`define FEAPC_MODE_LIM6 3'h6
`define FEAPC_MODE_LIM7 3'h7
`define FEAPC_GAIN_MIN 2'h0
`define FEAPC_GAIN_MAX 2'h3
// one quarter of the positive half of the 9-bit signed error range
`define FEAPC_QUARTER_RANGE 9'h040
`endif

// ===== hdl/feapc_avg.v
// sample history and plain mean over 2, 4 or 8 samples or weighted mean over 4 or 8 samples
// assumes push is a one-cycle pulse with a signed 9-bit sample
`timescale 1ns/1ns
module feapc_avg (
  input wire clk,
  input wire srst,
  input wire clear,
  input wire push,
  input wire signed [8:0] sample,
  input wire [1:0] depth,
  input wire weighted,
  output reg signed [8:0] mean
);
  reg signed [8:0] hist [0:7];
  reg signed [13:0] acc;
  integer i;

  // ----------------------------------------
  // history, index 0 newest
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst || clear) begin
      for (i = 0; i < 8; i = i + 1) begin
        hist[i] <= 9'h000;
      end
    end else if (push) begin
      hist[0] <= sample;
      for (i = 1; i < 8; i = i + 1) begin
        hist[i] <= hist[i-1];
      end
    end
  end

  // ----------------------------------------
  // mean, sum scaled by sixteen
  // ----------------------------------------
  always @* begin
    acc = 14'h0000;
    if (depth == 2'h1 && weighted) begin
      acc = 14'sd8 * hist[0] + 14'sd4 * hist[1] + 14'sd2 * hist[2] + 14'sd2 * hist[3];
    end else if (depth == 2'h2 && weighted) begin
      acc = 14'sd4 * hist[0] + 14'sd4 * hist[1]
        + 14'sd2 * hist[2] + 14'sd2 * hist[3]
        + hist[4] + hist[5] + hist[6] + hist[7];
    end else if (depth == 2'h1) begin
      acc = 14'sd4 * (hist[0] + hist[1] + hist[2] + hist[3]);
    end else if (depth == 2'h2) begin
      acc = 14'sd2 * (hist[0] + hist[1] + hist[2] + hist[3] + hist[4] + hist[5] + hist[6] + hist[7]);
    end else begin
      acc = 14'sd8 * (hist[0] + hist[1]);
    end
    mean = acc[12:4];
  end
endmodule

// ===== hdl/feapc_top.v
// error front end control channel: registers, sampling, averaging, gain, pre-bias
// assumes an AHB-Lite master with single word transfers and a converter that
// answers each convStart with one convDone pulse
`timescale 1ns/1ns
`include "feapc_defs.vh"
module feapc_top #(
  parameter NL_HIGH = 9'h0c0,
  parameter NL_LOW = 9'h020
) (
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire sampleTrig,
  input wire frameStart,
  input wire convDone,
  input wire [8:0] convData,
  input wire satHigh,
  input wire satLow,
  input wire rampActive,
  input wire satStepActive,
  input wire limitSarRequest,
  input wire [9:0] refLevel,
  input wire [9:0] measLevel,
  output reg convStart,
  output reg [8:0] filterData,
  output reg filterValid,
  output reg [1:0] gainSel,
  output wire [2:0] activeMode,
  output wire [7:0] stepWhole,
  output wire [9:0] stepFraction,
  output reg [13:0] satAdjust,
  output reg satAdjustValid,
  output wire rampComparatorEnable,
  output wire tripRaiseEnable,
  output wire tripLowerEnable,
  output wire swcapNoiseFilterEnable,
  output wire swcapLogicEnable,
  output wire errorConverterEnable,
  output wire swcapClockEnable,
  output reg [3:0] swcapCount,
  output wire prebiasEnable,
  output wire presetCompleteFlag
);
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [17:0] stepReg_r;
  reg [13:0] satStepReg_r;
  reg [28:0] ctrl_r;
  reg [17:0] prebias_r;
  reg [31:0] addrPh_r;
  reg wrPh_r;
  reg [3:0] decimCnt_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] burstCnt_r;
  reg [2:0] burstCnt_nxt;
  reg clkHalf_r;
  reg counterHeld_r;
  reg doneFlag_r;
  reg [7:0] pbCnt_r;
  reg [8:0] pendData_r;
  reg pendValid_r;
  wire signed [8:0] avgMean;
  wire [2:0] mode;
  wire avgMode;
  wire [3:0] depthN;
  wire acceptTrig;
  wire lastSample;
  wire signed [10:0] pbErr;
  wire [10:0] pbAbs;
  wire pbInRange;
  wire [8:0] absData;
  wire busTake;

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busTake = hsel && hready && htrans[1];

  always @(posedge sys_clk) begin
    if (srst) begin
      addrPh_r <= 32'h00000000;
      wrPh_r <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wrPh_r <= busTake && hwrite;
      if (busTake) begin
        addrPh_r <= haddr;
      end
      if (busTake && !hwrite) begin
        case (haddr)
          `FEAPC_ADDR_STATUS: hrdata <= {27'h0000000, prebias_r[`FEAPC_PB_EN], 3'h0, doneFlag_r};
          `FEAPC_ADDR_STEP: hrdata <= {14'h0000, stepReg_r};
          `FEAPC_ADDR_SATSTEP: hrdata <= {18'h00000, satStepReg_r};
          `FEAPC_ADDR_CTRL: hrdata <= {3'h0, ctrl_r};
          `FEAPC_ADDR_PREBIAS: hrdata <= {14'h0000, prebias_r};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      stepReg_r <= `FEAPC_RST_STEP;
      satStepReg_r <= `FEAPC_RST_SATSTEP;
      ctrl_r <= `FEAPC_RST_CTRL;
      prebias_r <= `FEAPC_RST_PREBIAS;
    end else if (wrPh_r) begin
      case (addrPh_r)
        `FEAPC_ADDR_STEP: stepReg_r <= hwdata[17:0];
        `FEAPC_ADDR_SATSTEP: satStepReg_r <= hwdata[13:0];
        `FEAPC_ADDR_CTRL: ctrl_r <= hwdata[28:0];
        `FEAPC_ADDR_PREBIAS: prebias_r <= hwdata[17:0];
        default: stepReg_r <= stepReg_r;
      endcase
    end
  end

  // ----------------------------------------
  // static control outputs
  // ----------------------------------------
  assign stepWhole = stepReg_r[17:10];
  assign stepFraction = stepReg_r[9:0];
  assign rampComparatorEnable = ctrl_r[`FEAPC_CTRL_CMPEN];
  assign tripRaiseEnable = ctrl_r[`FEAPC_CTRL_TRIPHI];
  assign tripLowerEnable = ctrl_r[`FEAPC_CTRL_TRIPLO];
  assign swcapNoiseFilterEnable = ctrl_r[`FEAPC_CTRL_NFILT];
  assign swcapLogicEnable = ctrl_r[`FEAPC_CTRL_SCEN];
  assign errorConverterEnable = ctrl_r[`FEAPC_CTRL_CONVEN];
  assign prebiasEnable = prebias_r[`FEAPC_PB_EN];
  assign presetCompleteFlag = doneFlag_r;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign mode = ctrl_r[`FEAPC_CTRL_MODE];
  assign activeMode = (mode == `FEAPC_MODE_LIM7 && limitSarRequest) ? `FEAPC_MODE_CSAR :
                      (mode == `FEAPC_MODE_LIM6 && limitSarRequest) ? `FEAPC_MODE_NSAR :
                      (mode == `FEAPC_MODE_LIM6 || mode == `FEAPC_MODE_LIM7) ? `FEAPC_MODE_STD : mode;
  assign avgMode = (mode == `FEAPC_MODE_AVG);
  assign depthN = (ctrl_r[`FEAPC_CTRL_DEPTH] == 2'h1) ? 4'h4 :
                  (ctrl_r[`FEAPC_CTRL_DEPTH] == 2'h2) ? 4'h8 : 4'h2;
  assign lastSample = ({1'b0, burstCnt_r} + 4'h1) == depthN;

  // ----------------------------------------
  // switched-cap clock enable and counter
  // ----------------------------------------
  assign swcapClockEnable = swcapLogicEnable && (ctrl_r[`FEAPC_CTRL_CLKFULL] || clkHalf_r);

  always @(posedge sys_clk) begin
    if (srst) begin
      clkHalf_r <= 1'b0;
      swcapCount <= 4'h0;
      counterHeld_r <= 1'b1;
    end else begin
      clkHalf_r <= !clkHalf_r;
      counterHeld_r <= ctrl_r[`FEAPC_CTRL_CCLR] || !swcapLogicEnable;
      if (ctrl_r[`FEAPC_CTRL_CCLR] || counterHeld_r) begin
        swcapCount <= ctrl_r[`FEAPC_CTRL_CPRE];
      end else if (frameStart && (ctrl_r[`FEAPC_CTRL_FSYNC] || mode == `FEAPC_MODE_PEAK)) begin
        swcapCount <= ctrl_r[`FEAPC_CTRL_CPRE];
      end else if (swcapClockEnable) begin
        swcapCount <= swcapCount + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // trigger decimation
  // ----------------------------------------
  assign acceptTrig = sampleTrig && (decimCnt_r == ctrl_r[`FEAPC_CTRL_DECIM]);

  always @(posedge sys_clk) begin
    if (srst || !errorConverterEnable) begin
      decimCnt_r <= 4'h0;
    end else if (sampleTrig) begin
      decimCnt_r <= acceptTrig ? 4'h0 : decimCnt_r + 4'h1;
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    burstCnt_nxt = burstCnt_r;
    case (state_r)
      ST_IDLE: begin
        if (acceptTrig && errorConverterEnable) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (convDone) begin
          if (avgMode) begin
            burstCnt_nxt = lastSample ? 3'h0 : burstCnt_r + 3'h1;
          end
          if (avgMode && !ctrl_r[`FEAPC_CTRL_SPATIAL] && !lastSample) begin
            state_nxt = ST_WAIT;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        burstCnt_nxt = 3'h0;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst || !errorConverterEnable) begin
      state_r <= ST_IDLE;
      burstCnt_r <= 3'h0;
      convStart <= 1'b0;
    end else begin
      state_r <= state_nxt;
      burstCnt_r <= burstCnt_nxt;
      convStart <= (state_r == ST_IDLE && state_nxt == ST_WAIT)
                   || (state_r == ST_WAIT && convDone && state_nxt == ST_WAIT);
    end
  end

  feapc_avg u_avg (
    .clk(sys_clk),
    .srst(srst),
    .clear(!avgMode),
    .push(state_r == ST_WAIT && convDone && avgMode),
    .sample(convData),
    .depth(ctrl_r[`FEAPC_CTRL_DEPTH]),
    .weighted(ctrl_r[`FEAPC_CTRL_WEIGHT] && avgMode),
    .mean(avgMean)
  );

  // ----------------------------------------
  // delivery to the loop filter
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      pendValid_r <= 1'b0;
      pendData_r <= 9'h000;
      filterValid <= 1'b0;
      filterData <= 9'h000;
    end else begin
      pendValid_r <= state_r == ST_WAIT && convDone && (!avgMode || lastSample);
      pendData_r <= convData;
      filterValid <= pendValid_r;
      if (pendValid_r) begin
        if (ctrl_r[`FEAPC_CTRL_INV]) begin
          filterData <= avgMode ? 9'h000 - avgMean : 9'h000 - pendData_r;
        end else begin
          filterData <= avgMode ? avgMean : pendData_r;
        end
      end
    end
  end

  // ----------------------------------------
  // automatic gain shifting
  // ----------------------------------------
  assign absData = convData[8] ? 9'h000 - convData : convData;

  always @(posedge sys_clk) begin
    if (srst) begin
      gainSel <= `FEAPC_GAIN_MAX;
    end else if (!ctrl_r[`FEAPC_CTRL_AGEN]) begin
      gainSel <= ctrl_r[`FEAPC_CTRL_GAIN];
    end else if (convDone) begin
      if (!ctrl_r[`FEAPC_CTRL_AGMODE]) begin
        if ((satHigh || satLow) && gainSel != `FEAPC_GAIN_MIN) begin
          gainSel <= gainSel - 2'h1;
        end else if (!satHigh && !satLow && absData < `FEAPC_QUARTER_RANGE && gainSel != `FEAPC_GAIN_MAX) begin
          gainSel <= gainSel + 2'h1;
        end
      end else begin
        if (absData >= NL_HIGH && gainSel != `FEAPC_GAIN_MIN) begin
          gainSel <= gainSel - 2'h1;
        end else if (absData < NL_LOW && gainSel != `FEAPC_GAIN_MAX) begin
          gainSel <= gainSel + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // saturation step during ramp
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      satAdjust <= 14'h0000;
      satAdjustValid <= 1'b0;
    end else begin
      satAdjust <= satStepReg_r;
      satAdjustValid <= convDone && (satHigh || satLow) && rampActive
                        && satStepActive && satStepReg_r != 14'h0000;
    end
  end

  // ----------------------------------------
  // pre-bias completion with hysteresis
  // ----------------------------------------
  assign pbErr = prebias_r[`FEAPC_PB_POL] ? {1'b0, measLevel} - {1'b0, refLevel}
                                          : {1'b0, refLevel} - {1'b0, measLevel};
  assign pbAbs = pbErr[10] ? 11'h000 - pbErr : pbErr;
  assign pbInRange = pbAbs <= {3'h0, prebias_r[`FEAPC_PB_RANGE]};

  always @(posedge sys_clk) begin
    if (srst || !prebias_r[`FEAPC_PB_EN]) begin
      doneFlag_r <= 1'b0;
      pbCnt_r <= 8'h00;
    end else if (convDone) begin
      if (pbInRange != doneFlag_r) begin
        if (pbCnt_r + 8'h01 >= prebias_r[`FEAPC_PB_LIMIT] || prebias_r[`FEAPC_PB_LIMIT] == 8'h00) begin
          doneFlag_r <= pbInRange;
          pbCnt_r <= 8'h00;
        end else begin
          pbCnt_r <= pbCnt_r + 8'h01;
        end
      end else begin
        pbCnt_r <= 8'h00;
      end
    end
  end
endmodule

// ===== testbench/feapc_properties.sv
// checker for the error front end, bound onto feapc_top
// assumes it sees only the ports of feapc_top
`timescale 1ns/1ns
`include "feapc_defs.vh"
module feapc_properties (
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire sampleTrig,
  input wire convDone,
  input wire satHigh,
  input wire satLow,
  input wire rampActive,
  input wire satStepActive,
  input wire convStart,
  input wire filterValid,
  input wire [13:0] satAdjust,
  input wire satAdjustValid,
  input wire [7:0] stepWhole,
  input wire [9:0] stepFraction,
  input wire rampComparatorEnable,
  input wire tripRaiseEnable,
  input wire tripLowerEnable,
  input wire prebiasEnable,
  input wire presetCompleteFlag
);
  // ----
  // write data phases
  // ----
  reg wrStep_r;
  reg wrCtrl_r;
  wire wrAddr = hsel && hready && htrans[1] && hwrite;
  always @(posedge sys_clk) begin
    wrStep_r <= wrAddr && haddr == `FEAPC_ADDR_STEP;
    wrCtrl_r <= wrAddr && haddr == `FEAPC_ADDR_CTRL;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ----
  // properties
  // ----
  property p_step_write;
    $changed({stepWhole, stepFraction}) |-> $past(wrStep_r);
  endproperty
  a_step_write: assert property (p_step_write) else $error("step changed without write");
  property p_ctrl_write;
    $changed({rampComparatorEnable, tripRaiseEnable, tripLowerEnable}) |-> $past(wrCtrl_r);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("comparator bits changed without write");
  property p_start_cause;
    convStart |-> $past(sampleTrig) || $past(convDone);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without trigger");
  property p_start_pulse;
    convStart |=> !convStart;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_filter_after_done;
    filterValid |-> $past(convDone, 2);
  endproperty
  a_filter_after_done: assert property (p_filter_after_done) else $error("delivery without conversion");
  property p_sat_cause;
    satAdjustValid |-> $past(convDone && (satHigh || satLow) && rampActive && satStepActive) && satAdjust != 14'h0;
  endproperty
  a_sat_cause: assert property (p_sat_cause) else $error("saturation step without cause");
  property p_flag_rise;
    $rose(presetCompleteFlag) |-> $past(convDone) && prebiasEnable;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without sample");
  property p_flag_fall;
    $fell(presetCompleteFlag) |-> $past(convDone) || !prebiasEnable;
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without sample");
  c_filter: cover property (filterValid);
  c_sat: cover property (satAdjustValid);
  c_flag: cover property ($rose(presetCompleteFlag));
endmodule
bind feapc_top feapc_properties u_props (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hready, .sampleTrig,
  .convDone, .satHigh, .satLow, .rampActive, .satStepActive, .convStart, .filterValid, .satAdjust, .satAdjustValid,
  .stepWhole, .stepFraction, .rampComparatorEnable, .tripRaiseEnable, .tripLowerEnable, .prebiasEnable,
  .presetCompleteFlag);

// ===== testbench/feapc_conv_model.sv
// converter model: one convDone for each convStart, prompt or slow
// assumes the bench supplies sample value and saturation level
`timescale 1ns/1ns
module feapc_conv_model (
  input wire clk,
  input wire srst,
  input wire convStart,
  input wire slow,
  input wire [8:0] dataIn,
  input wire satIn,
  output reg convDone,
  output reg [8:0] convData,
  output reg satHigh,
  output reg satLow
);
  int waitCnt = 0;
  bit busy = 1'b0;
  initial begin
    convDone = 1'b0;
    convData = 9'h0;
    satHigh = 1'b0;
    satLow = 1'b0;
  end
  // data line shows the inverse of its last value outside a result
  always @(posedge clk) begin
    convDone <= 1'b0;
    satHigh <= 1'b0;
    convData <= ~convData;
    if (srst) begin
      busy = 1'b0;
    end else if (busy && waitCnt == 0) begin
      busy = 1'b0;
      convDone <= 1'b1;
      convData <= dataIn;
      satHigh <= satIn;
    end else if (busy) begin
      waitCnt--;
    end
    if (convStart && !srst) begin
      busy = 1'b1;
      waitCnt = slow ? 4 : 0;
    end
  end
endmodule

// ===== testbench/feapc_top_tb.sv
// self-checking bench for the error front end
// assumes feapc_top, its checker and the converter model
`timescale 1ns/1ns
`include "feapc_defs.vh"
module feapc_top_tb;
  logic sys_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sampleTrig = 1'b0, frameStart = 1'b0;
  logic rampActive = 1'b0, satStepActive = 1'b0, limitSarRequest = 1'b0, slow = 1'b0, satIn = 1'b0;
  logic hreadyout, hresp, convDone, satHigh, satLow, convStart, filterValid, satAdjustValid;
  logic rampComparatorEnable, tripRaiseEnable, tripLowerEnable, swcapNoiseFilterEnable, swcapLogicEnable;
  logic errorConverterEnable, swcapClockEnable, prebiasEnable, presetCompleteFlag;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v;
  logic [1:0] htrans = 2'h0, gainSel;
  logic [2:0] hsize = 3'h2, activeMode;
  logic [9:0] refLevel = 10'h180, measLevel = 10'h0, stepFraction;
  logic [8:0] dataIn = 9'h0, convData, filterData;
  logic [7:0] stepWhole;
  logic [13:0] satAdjust, satStep = 14'h0;
  logic [3:0] swcapCount;
  logic [28:0] cv = 29'h3f;
  logic signed [8:0] hist[$];
  logic [31:0] adr[6] = '{`FEAPC_ADDR_STEP, `FEAPC_ADDR_SATSTEP, `FEAPC_ADDR_CTRL, `FEAPC_ADDR_PREBIAS,
    `FEAPC_ADDR_STATUS, 32'h000e003c};
  logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h3f, 32'hff00, 32'h0, 32'h0};
  logic [31:0] msk[4] = '{32'h3ffff, 32'h3fff, 32'h1fffffff, 32'h3ffff};
  integer seed = 32'hc88f9f4f;
  int nErrors = 0, totalChecks = 0, nStart = 0, nValid = 0, nSat = 0, k, n;
  wire hready = hreadyout;
  feapc_top uut (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .sampleTrig, .frameStart, .convDone, .convData, .satHigh, .satLow, .rampActive, .satStepActive,
    .limitSarRequest, .refLevel, .measLevel, .convStart, .filterData, .filterValid, .gainSel, .activeMode,
    .stepWhole, .stepFraction, .satAdjust, .satAdjustValid, .rampComparatorEnable, .tripRaiseEnable,
    .tripLowerEnable, .swcapNoiseFilterEnable, .swcapLogicEnable, .errorConverterEnable, .swcapClockEnable,
    .swcapCount, .prebiasEnable, .presetCompleteFlag);
  feapc_conv_model conv (.clk(sys_clk), .srst, .convStart, .slow, .dataIn, .satIn, .convDone, .convData,
    .satHigh, .satLow);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    dataIn <= 9'($random(seed));
    frameStart <= ($random(seed) & 15) == 0;
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, g);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic completeRun();
    if (nErrors == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  task automatic ctrl(input logic [28:0] c);
    cv = c;
    bus(1'b1, `FEAPC_ADDR_CTRL, {3'h0, c});
    hist.delete();
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic trig(input int cnt, gap);
    repeat (cnt) begin
      @(posedge sys_clk);
      sampleTrig <= 1'b1;
      @(posedge sys_clk);
      sampleTrig <= 1'b0;
      repeat (gap) @(posedge sys_clk);
    end
  endtask
  function automatic logic [8:0] expect9(int cnt, bit w);
    int s, j;
    s = 0;
    for (int i = 0; i < cnt; i++) begin
      j = hist.size() - cnt + i;
      if (j >= 0) s += (!w || i < cnt / 2 ? 1 : i < cnt - 2 || i == 2 ? 2 : 4) * hist[j];
    end
    s = s >>> (!w ? $clog2(cnt) : cnt == 4 ? 3 : 4);
    return 9'(cv[15] ? -s : s);
  endfunction
  // ----
  // reference model of the delivered data
  // ----
  always @(posedge sys_clk) begin
    if (!srst) begin
      n = cv[8:6] != 3'h1 ? 1 : 2 << cv[10:9];
      if (filterValid) begin
        nValid++;
        chk("filterData", expect9(n, cv[12] && n > 2), filterData);
      end
      if (convDone) hist.push_back(convData);
      if (convStart) nStart++;
      if (satAdjustValid) begin
        nSat++;
        chk("satAdjust", satStep, satAdjust);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    nErrors++;
    completeRun();
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, adr[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    chk("gainSel", 2'h3, gainSel);
    chk("enables", 6'h7, {rampComparatorEnable, tripRaiseEnable, tripLowerEnable, swcapNoiseFilterEnable,
      swcapLogicEnable, errorConverterEnable});
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & msk[i];
      bus(1'b1, adr[i], v);
      bus(1'b0, adr[i], 32'h0);
      chk("read back", v, rd);
      if (i == 0) chk("step", v[17:0], {stepWhole, stepFraction});
      if (i == 2) chk("ctrl bits", {v[28:26], v[3], v[1:0]}, {rampComparatorEnable, tripRaiseEnable,
        tripLowerEnable, swcapNoiseFilterEnable, swcapLogicEnable, errorConverterEnable});
    end
    bus(1'b1, `FEAPC_ADDR_PREBIAS, 32'h0);
    for (int m = 0; m < 8; m++) begin
      ctrl(29'(m * 64 + (m % 4) * 16 + 15));
      for (int l = 0; l < 2; l++) begin
        limitSarRequest <= l[0];
        repeat (2) @(posedge sys_clk);
        if (m != 4) chk("activeMode", m < 6 ? m : l ? m - 4 : 0, activeMode);
      end
      chk("gainSel", m % 4, gainSel);
    end
    for (int c = 0; c < 3; c++) begin
      ctrl(29'(9 + (c < 2) * 2 + (c == 0) * 4));
      k = 0;
      repeat (8) begin
        @(posedge sys_clk);
        k += swcapClockEnable;
      end
      chk("swcap clock", c == 0 ? 8 : c == 1 ? 4 : 0, k);
    end
    ctrl(29'h19000f);
    repeat (4) @(posedge sys_clk);
    chk("counter held", 4'h9, swcapCount);
    ctrl(29'h09000f);
    repeat (3) @(posedge sys_clk);
    chk("counter runs", 1'b1, swcapCount !== 4'h9);
    for (int f = 0; f < 2; f++) begin
      ctrl(f ? 29'h05014f : 29'h25000f);
      do @(posedge sys_clk); while (frameStart !== 1'b1);
      @(posedge sys_clk);
      chk("frame preset", 4'h5, swcapCount);
    end
    for (int d = 0; d < 3; d++) begin
      k = d == 0 ? 0 : d == 1 ? 2 : 15;
      ctrl(29'(k * 32'h400000 + (d == 1) * 32'h8000 + 15));
      nStart = 0;
      nValid = 0;
      trig(2 * (k + 1), 8);
      chk("starts", 2, nStart);
      chk("deliveries", 2, nValid);
    end
    for (int c = 0; c < 12; c++) begin
      k = 2 << (c % 3);
      ctrl(29'hf);
      ctrl(29'(79 + (c % 3) * 512 + (c / 3 % 2) * 4096 + (c / 6) * 34816));
      slow <= c[0];
      nStart = 0;
      nValid = 0;
      if (c < 6) trig(2, 80);
      else trig(2 * k, 12);
      chk("starts", 2 * k, nStart);
      chk("means", 2, nValid);
    end
    slow <= 1'b0;
    satStep = 14'h155;
    bus(1'b1, `FEAPC_ADDR_SATSTEP, 32'h155);
    ctrl(29'h3f);
    ctrl(29'h203f);
    rampActive <= 1'b1;
    satStepActive <= 1'b1;
    satIn <= 1'b1;
    nSat = 0;
    trig(1, 8);
    chk("sat pulses", 1, nSat);
    chk("gainSel", 2'h2, gainSel);
    bus(1'b1, `FEAPC_ADDR_SATSTEP, 32'h0);
    trig(1, 8);
    chk("sat pulses", 1, nSat);
    satIn <= 1'b0;
    rampActive <= 1'b0;
    ctrl(29'hf);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, `FEAPC_ADDR_PREBIAS, 32'h11003 | p << 17);
      measLevel <= 10'h185;
      trig(2, 8);
      chk("flag early", 1'b0, presetCompleteFlag);
      trig(2, 8);
      bus(1'b0, `FEAPC_ADDR_STATUS, 32'h0);
      chk("status", 32'h11, rd);
      chk("prebiasEnable", 1'b1, prebiasEnable);
      measLevel <= 10'h1a8;
      trig(2, 8);
      chk("flag held", 1'b1, presetCompleteFlag);
      trig(2, 8);
      chk("flag cleared", 1'b0, presetCompleteFlag);
      bus(1'b1, `FEAPC_ADDR_PREBIAS, 32'h0);
    end
    completeRun();
  end
endmodule
